// ==== csrl_defs.vh ====
// Constants for the chiller status relay logic
`ifndef CSRL_DEFS_VH
`define CSRL_DEFS_VH
// Register byte offsets
`define CSRL_OFS_SEL        8'h00
`define CSRL_OFS_RELIEF     8'h04
`define CSRL_OFS_STATUS     8'h08
`define CSRL_OFS_CMD        8'h0c
`define CSRL_OFS_INT_STAT   8'h10
`define CSRL_OFS_INT_MASK   8'h14
// Event select codes
`define CSRL_EV_LATCH       3'h0
`define CSRL_EV_AUTO        3'h1
`define CSRL_EV_ALARM       3'h2
`define CSRL_EV_WARN        3'h3
`define CSRL_EV_LIMIT       3'h4
`define CSRL_EV_COMP        3'h5
`define CSRL_EV_RELIEF      3'h6
// Reset values
`define CSRL_SEL_RESET      12'haa6
`define CSRL_RELIEF_RESET   16'h003c
`define CSRL_MASK_RESET     8'h00
`define CSRL_PIN_RESET      3'h3
// Command register bit positions
`define CSRL_CMD_ESTOP_CLR  0
`define CSRL_CMD_PANIC_CLR  1
// Status register field positions
`define CSRL_STAT_EV        0
`define CSRL_STAT_RELAY     7
`define CSRL_STAT_RUN       11
`define CSRL_STAT_UNLOAD    12
`define CSRL_STAT_PANIC     13
`define CSRL_STAT_ESTOP     14
`define CSRL_STAT_ARMED     15
// Timing
`define CSRL_CLK_HZ         25000000
`define CSRL_TICK_S         1
`define CSRL_TICK_CYCLES    (`CSRL_CLK_HZ * `CSRL_TICK_S)
`define CSRL_LIM_ON_MIN     20
`define CSRL_LIM_OFF_MIN    1
`define CSRL_LIM_ON_S       (`CSRL_LIM_ON_MIN * 60)
`define CSRL_LIM_OFF_S      (`CSRL_LIM_OFF_MIN * 60)
`define CSRL_PANIC_WIN_S    3
`endif

// ==== csrl_top.v ====
// Status and alarm relay logic with APB register access
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "csrl_defs.vh"

module csrl_top #(
  parameter N_DIAG      = 8,                  // Diagnostic sources
  parameter N_COMP      = 2,                  // Compressors
  parameter TICK_CYCLES = `CSRL_TICK_CYCLES   // Clock cycles per second
) (
  // Clock and reset
  input  wire                REF_CLK_I,
  input  wire                RESET_I,
  // APB slave
  input  wire                PSEL_I,
  input  wire                PENABLE_I,
  input  wire                PWRITE_I,
  input  wire [7:0]          PADDR_I,
  input  wire [31:0]         PWDATA_I,
  output reg  [31:0]         PRDATA_O,
  output reg                 PREADY_O,
  output reg                 PSLVERR_O,
  // Diagnostics
  input  wire [N_DIAG-1:0]   DIAG_ACTIVE_I,
  input  wire [N_DIAG-1:0]   DIAG_MANUAL_I,
  input  wire [N_DIAG-1:0]   DIAG_INFO_I,
  // Operating state
  input  wire [3:0]          LIMIT_INHIBIT_I,
  input  wire [N_COMP-1:0]   COMP_RUN_I,
  input  wire                ICE_MODE_I,
  input  wire                COND_LIMIT_I,
  // Customer contacts
  input  wire                ESTOP_CLOSED_I,
  input  wire                AUTO_CLOSED_I,
  input  wire                STOP_BTN_I,
  // Relay and unit outputs
  output reg  [3:0]          RELAY_O,
  output reg                 RUN_ENABLE_O,
  output reg                 UNLOAD_O,
  output reg                 PANIC_STOP_O,
  output reg                 ESTOP_TRIP_O,
  output reg                 IRQ_O
);

  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
  // Timing counts as plain integers, then cut to counter width
  localparam integer LIM_ON_S  = `CSRL_LIM_ON_S;     // Limit set, seconds
  localparam integer LIM_OFF_S = `CSRL_LIM_OFF_S;    // Limit clear, seconds
  localparam integer WIN_S     = `CSRL_PANIC_WIN_S;  // Panic window, seconds
  localparam [10:0]  LIM_ON    = LIM_ON_S[10:0];
  localparam [10:0]  LIM_OFF   = LIM_OFF_S[10:0];
  localparam [3:0]   PANIC_WIN = WIN_S[3:0];
  localparam [2:0]   PIN_RESET = `CSRL_PIN_RESET;    // Contacts closed

  // Select one event from the event vector
  function sel_event;
    input [2:0] sel;
    input [6:0] ev;
    begin
      case (sel)
        `CSRL_EV_LATCH:  sel_event = ev[0];
        `CSRL_EV_AUTO:   sel_event = ev[1];
        `CSRL_EV_ALARM:  sel_event = ev[2];
        `CSRL_EV_WARN:   sel_event = ev[3];
        `CSRL_EV_LIMIT:  sel_event = ev[4];
        `CSRL_EV_COMP:   sel_event = ev[5];
        `CSRL_EV_RELIEF: sel_event = ev[6];
        default:         sel_event = 1'b0;
      endcase
    end
  endfunction

  // Address decode: true for a mapped register
  function addr_hit;
    input [7:0] a;
    begin
      case (a)
        `CSRL_OFS_SEL, `CSRL_OFS_RELIEF, `CSRL_OFS_STATUS,
        `CSRL_OFS_CMD, `CSRL_OFS_INT_STAT, `CSRL_OFS_INT_MASK:
          addr_hit = 1'b1;
        default:
          addr_hit = 1'b0;
      endcase
    end
  endfunction

  reg  [31:0]       tick_cnt;      // Second prescaler
  reg               tick;          // One pulse per second
  reg  [2:0]        sync_a;        // Pin synchroniser stage 1
  reg  [2:0]        sync_b;        // Pin synchroniser stage 2
  reg  [2:0]        sync_c;        // Pin synchroniser stage 3
  reg  [2:0]        pin_f;         // Filtered pins
  reg               btn_prev;      // Button level last cycle
  reg  [11:0]       relay_sel;     // Four 3-bit event selects
  reg  [15:0]       relief_time;   // Relief filter time, seconds
  reg  [7:0]        int_stat;      // Sticky event bits
  reg  [7:0]        int_mask;      // Interrupt enables
  reg  [7:0]        ev_prev;       // Events last cycle
  reg  [10:0]       lim_cnt;       // Limit filter seconds
  reg               lim_mode;      // Filtered limit mode
  reg  [15:0]       rel_cnt;       // Relief filter seconds
  reg               relief;        // Filtered relief request
  reg               estop_trip;    // Latched stop trip
  reg               panic;         // Panic stop active
  reg               armed;         // First stop press seen
  reg  [3:0]        win_cnt;       // Panic window seconds
  reg  [31:0]       rd_val;        // Read mux

  // Event classes; informational diagnostics never count as alarms,
  // and a stop trip is a manual-reset fault so it joins the latch and alarm classes
  wire [N_DIAG-1:0] d_real  = DIAG_ACTIVE_I & ~DIAG_INFO_I;
  wire              ev_latch = (|(d_real & DIAG_MANUAL_I)) | estop_trip;
  wire              ev_auto  = |(d_real & ~DIAG_MANUAL_I);
  wire              ev_alarm = (|d_real) | estop_trip;
  wire              ev_warn  = |(DIAG_ACTIVE_I & DIAG_INFO_I);
  wire              ev_comp  = |COMP_RUN_I;
  wire              lim_any  = |LIMIT_INHIBIT_I;
  wire              rel_any  = ICE_MODE_I | COND_LIMIT_I;
  wire [6:0]        ev_now   = {relief, ev_comp, lim_mode, ev_warn,
                                ev_alarm, ev_auto, ev_latch};
  wire [7:0]        ev_all   = {panic, ev_now};
  // Button edge, bus decode and filter thresholds
  wire              press    = pin_f[2] & ~btn_prev;
  wire              apb_acc  = PSEL_I & PENABLE_I;
  wire              apb_done = apb_acc & PREADY_O;
  wire              hit      = addr_hit(PADDR_I);
  wire              wr       = apb_done & PWRITE_I & hit;
  wire              rd_int   = apb_done & ~PWRITE_I &
                               (PADDR_I == `CSRL_OFS_INT_STAT);
  wire [10:0]       lim_thr  = lim_mode ? LIM_OFF : LIM_ON;
  wire [7:0]        int_clr  = rd_int ? PRDATA_O[7:0] : 8'h00;

  // One-second time base; the limit and relief filters count its pulses, so the real
  // delay is the threshold less up to one second of tick phase
  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_LAST) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  // Three-stage pin synchronisers with agreement filter
  // Contacts may bounce; a level not yet settled in stages two and three
  // leaves the filtered value where it was
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      always @(posedge REF_CLK_I) begin
        if (RESET_I) begin
          sync_a[g] <= PIN_RESET[g];
          sync_b[g] <= PIN_RESET[g];
          sync_c[g] <= PIN_RESET[g];
          pin_f[g]  <= PIN_RESET[g];
        end else begin
          sync_a[g] <= (g == 0) ? ESTOP_CLOSED_I :
                       (g == 1) ? AUTO_CLOSED_I : STOP_BTN_I;
          sync_b[g] <= sync_a[g];
          sync_c[g] <= sync_b[g];
          // Accept a change once stages two and three agree
          if (sync_b[g] == sync_c[g]) begin
            pin_f[g] <= sync_c[g];
          end
        end
      end
    end
  endgenerate

  // Relay drive, one per output
  // Each relay follows its selected event one clock later; code 7 is off
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_relay
      always @(posedge REF_CLK_I) begin
        if (RESET_I) begin
          RELAY_O[g] <= 1'b0;
        end else begin
          RELAY_O[g] <= sel_event(relay_sel[3*g +: 3], ev_now);
        end
      end
    end
  endgenerate

  // Limit mode filter, restarts when interrupted
  // The counter runs only while input and state differ, so any return to
  // the present state throws the partial count away
  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      lim_cnt  <= 11'h000;
      lim_mode <= 1'b0;
    end else if (lim_any == lim_mode) begin
      lim_cnt  <= 11'h000;
    end else if (lim_cnt >= lim_thr) begin
      lim_mode <= lim_any;
      lim_cnt  <= 11'h000;
    end else if (tick) begin
      lim_cnt  <= lim_cnt + 11'h001;
    end
  end

  // Head pressure relief filter, same time both ways
  // A relief time of zero makes the request follow its modes directly
  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      rel_cnt <= 16'h0000;
      relief  <= 1'b0;
    end else if (rel_any == relief) begin
      rel_cnt <= 16'h0000;
    end else if (rel_cnt >= relief_time) begin
      relief  <= rel_any;
      rel_cnt <= 16'h0000;
    end else if (tick) begin
      rel_cnt <= rel_cnt + 16'h0001;
    end
  end

  // Emergency stop trip and panic stop
  // An open contact beats a clear command in the same cycle, so a trip
  // can only be cleared once the loop is closed again
  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      estop_trip <= 1'b0;
      panic      <= 1'b0;
      armed      <= 1'b0;
      win_cnt    <= 4'h0;
      btn_prev   <= 1'b0;
    end else begin
      btn_prev <= pin_f[2];
      // Open contact trips; clear only by command with contact closed
      if (!pin_f[0]) begin
        estop_trip <= 1'b1;
      end else if (wr && PADDR_I == `CSRL_OFS_CMD &&
                   PWDATA_I[`CSRL_CMD_ESTOP_CLR]) begin
        estop_trip <= 1'b0;
      end
      // Second press within window stops at once, no latch
      if (press && armed) begin
        panic   <= 1'b1;
        armed   <= 1'b0;
      end else if (wr && PADDR_I == `CSRL_OFS_CMD &&
                   PWDATA_I[`CSRL_CMD_PANIC_CLR]) begin
        panic   <= 1'b0;
      end
      if (press && !armed) begin
        armed   <= 1'b1;
        win_cnt <= 4'h0;
      end else if (armed && tick) begin
        if (win_cnt >= PANIC_WIN) begin
          armed <= 1'b0;
        end
        win_cnt <= win_cnt + 4'h1;
      end
    end
  end

  // Unit run control outputs
  // The unit may run only with both loops closed and no stop pending
  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      RUN_ENABLE_O <= 1'b0;
      UNLOAD_O     <= 1'b0;
      PANIC_STOP_O <= 1'b0;
      ESTOP_TRIP_O <= 1'b0;
    end else begin
      // Reclosed auto contact resumes by itself
      RUN_ENABLE_O <= pin_f[0] & ~estop_trip & pin_f[1] & ~panic;
      UNLOAD_O     <= ~pin_f[1] & ev_comp;
      PANIC_STOP_O <= panic;
      ESTOP_TRIP_O <= estop_trip;
    end
  end

  // Configuration registers
  // Writes land on the completing access edge; unmapped writes are dropped
  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      relay_sel   <= `CSRL_SEL_RESET;
      relief_time <= `CSRL_RELIEF_RESET;
      int_mask    <= `CSRL_MASK_RESET;
    end else if (wr) begin
      case (PADDR_I)
        `CSRL_OFS_SEL:      relay_sel   <= PWDATA_I[11:0];
        `CSRL_OFS_RELIEF:   relief_time <= PWDATA_I[15:0];
        `CSRL_OFS_INT_MASK: int_mask    <= PWDATA_I[7:0];
        default:            int_mask    <= int_mask;
      endcase
    end
  end

  // Sticky event flags, set wins over read clear
  // Only rising edges set a flag; the clear uses the word just returned,
  // so an edge that arrives after the read is kept for the next one
  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      int_stat <= 8'h00;
      ev_prev  <= 8'h00;
      IRQ_O    <= 1'b0;
    end else begin
      ev_prev  <= ev_all;
      int_stat <= (int_stat & ~int_clr) | (ev_all & ~ev_prev);
      IRQ_O    <= |(int_stat & int_mask);
    end
  end

  // Read data mux
  // Write-only and unmapped offsets read as zero
  always @* begin
    rd_val = 32'h0000_0000;
    case (PADDR_I)
      `CSRL_OFS_SEL:      rd_val[11:0] = relay_sel;
      `CSRL_OFS_RELIEF:   rd_val[15:0] = relief_time;
      `CSRL_OFS_STATUS: begin
        rd_val[`CSRL_STAT_EV +: 7]    = ev_now;
        rd_val[`CSRL_STAT_RELAY +: 4] = RELAY_O;
        rd_val[`CSRL_STAT_RUN]        = RUN_ENABLE_O;
        rd_val[`CSRL_STAT_UNLOAD]     = UNLOAD_O;
        rd_val[`CSRL_STAT_PANIC]      = panic;
        rd_val[`CSRL_STAT_ESTOP]      = estop_trip;
        rd_val[`CSRL_STAT_ARMED]      = armed;
      end
      `CSRL_OFS_INT_STAT: rd_val[7:0]  = int_stat;
      `CSRL_OFS_INT_MASK: rd_val[7:0]  = int_mask;
      default:            rd_val       = 32'h0000_0000;
    endcase
  end

  // APB answer: one wait state, error on unmapped address
  // Ready rises one cycle into the access phase and falls straight after
  always @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else if (apb_acc && !PREADY_O) begin
      PREADY_O  <= 1'b1;
      PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_val;
      PSLVERR_O <= ~hit;
    end else begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

endmodule

// ==== csrl_checker.sv ====
// Port checks for the status relay block
`timescale 1ns/10ps
module csrl_checker #(
  parameter N_COMP = 2  // Compressors
) (
  // Clock and reset
  input wire              REF_CLK_I,
  input wire              RESET_I,
  // APB
  input wire              PSEL_I,
  input wire              PWRITE_I,
  input wire              PENABLE_I,
  input wire [31:0]       PRDATA_O,
  input wire              PREADY_O,
  input wire              PSLVERR_O,
  // Unit state
  input wire [N_COMP-1:0] COMP_RUN_I,
  input wire              ESTOP_CLOSED_I,
  input wire              AUTO_CLOSED_I,
  input wire              RUN_ENABLE_O,
  input wire              UNLOAD_O,
  input wire              PANIC_STOP_O,
  input wire              ESTOP_TRIP_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  // Setup then first access cycle
  sequence s_access;
    PSEL_I && !PENABLE_I ##1 PSEL_I && PENABLE_I;
  endsequence
  // Contacts held open past the pin filter
  sequence s_estop_open;
    !ESTOP_CLOSED_I [*6];
  endsequence
  sequence s_auto_open;
    !AUTO_CLOSED_I [*6];
  endsequence
  // No register write now or one cycle ago
  sequence s_no_wr;
    !(PSEL_I && PWRITE_I) && !($past(PSEL_I) && $past(PWRITE_I));
  endsequence
  property p_ready; s_access |=> PREADY_O; endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  property p_pulse; PREADY_O |=> !PREADY_O; endproperty
  a_pulse: assert property (p_pulse) else $error("ready stuck");
  property p_errdata; PREADY_O && PSLVERR_O |-> PRDATA_O == 32'h0; endproperty
  a_errdata: assert property (p_errdata) else $error("error data");
  property p_run;
    RUN_ENABLE_O |-> !ESTOP_TRIP_O && !PANIC_STOP_O && !UNLOAD_O;
  endproperty
  a_run: assert property (p_run) else $error("run while stopped");
  property p_unload; UNLOAD_O |-> $past(|COMP_RUN_I); endproperty
  a_unload: assert property (p_unload) else $error("unload idle");
  property p_trip; s_estop_open |=> ESTOP_TRIP_O; endproperty
  a_trip: assert property (p_trip) else $error("no trip");
  property p_inhibit; s_auto_open |=> !RUN_ENABLE_O; endproperty
  a_inhibit: assert property (p_inhibit) else $error("not inhibited");
  property p_latch; ESTOP_TRIP_O ##0 s_no_wr |=> ESTOP_TRIP_O; endproperty
  a_latch: assert property (p_latch) else $error("trip lost");
  property p_panic; PANIC_STOP_O ##0 s_no_wr |=> PANIC_STOP_O; endproperty
  a_panic: assert property (p_panic) else $error("panic lost");
endmodule

// ==== csrl_contacts.sv ====
// Customer stop loop, auto/stop loop and stop button
`timescale 1ns/10ps
module csrl_contacts (
  // Clock and requested positions
  input  wire clk,
  input  wire estop_open,
  input  wire auto_open,
  input  wire press,
  // Contact pins
  output reg  estop_closed = 1'b1,
  output reg  auto_closed  = 1'b1,
  output reg  stop_btn     = 1'b0
);
  reg [2:0] hold = 3'h0;  // Button hold count
  // Contacts follow requests; a press lasts seven cycles
  always @(posedge clk) begin
    estop_closed <= !estop_open;
    auto_closed  <= !auto_open;
    hold         <= press ? 3'h6 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
    stop_btn     <= press || hold != 3'h0;
  end
endmodule

// ==== csrl_test.sv ====
// Self-checking bench for the status relay block
`timescale 1ns/10ps
module csrl_test;
  localparam T = 10;  // Cycles per second tick
  reg        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  reg [7:0]  paddr = 8'h00, da = 8'h00, dm = 8'h00, di = 8'h00;
  reg [31:0] pwdata = 32'h0, rdata;
  reg [3:0]  lim = 4'h0, ev;
  reg [1:0]  comp = 2'h0;
  reg        ice = 1'b0, cond = 1'b0, eo = 1'b0, ao = 1'b0, press = 1'b0;
  reg        rerr;
  wire [31:0] prdata;
  wire [3:0]  relay;
  wire       pready, pslverr, run, unl, panic, trip, irq, es, ac, sb;
  integer    error_cnt = 0, checked = 0, i;
  csrl_top #(.TICK_CYCLES(T)) u_dut (
    .REF_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .DIAG_ACTIVE_I(da),
    .DIAG_MANUAL_I(dm), .DIAG_INFO_I(di), .LIMIT_INHIBIT_I(lim),
    .COMP_RUN_I(comp), .ICE_MODE_I(ice), .COND_LIMIT_I(cond),
    .ESTOP_CLOSED_I(es), .AUTO_CLOSED_I(ac), .STOP_BTN_I(sb),
    .RELAY_O(relay), .RUN_ENABLE_O(run), .UNLOAD_O(unl),
    .PANIC_STOP_O(panic), .ESTOP_TRIP_O(trip), .IRQ_O(irq));
  csrl_contacts u_contacts (.clk(clk), .estop_open(eo), .auto_open(ao),
    .press(press), .estop_closed(es), .auto_closed(ac), .stop_btn(sb));
  // Clock
  always #20 clk = ~clk;
  // One APB transfer, held until ready
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
        @(posedge clk);
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  // Word compare
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("wrong value %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Bit compare
  task chk1(input string nm, input e, input g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // Read and compare masked field
  task rchk(input string nm, input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdata & m);
    end
  endtask
  task secs(input integer s);
    repeat (s * T) @(posedge clk);
  endtask
  // One short button press
  task push;
    begin
      press <= 1'b1;
      @(posedge clk);
      press <= 1'b0;
      repeat (15) @(posedge clk);
    end
  endtask
  // Verdict
  task stop_test;
    begin
      $display("errors %0d checked %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #2400000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk("sel", 8'h00, 32'hfff, 32'haa6);
    rchk("relief", 8'h04, 32'hffff, 32'h3c);
    rchk("mask", 8'h14, 32'hff, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk1("slverr", 1'b1, rerr);
    chk("err data", 32'h0, rdata);
    // Relief filter, 5 s, ice then condenser limit
    apb(1'b1, 8'h04, 32'h5);
    ice <= 1'b1;
    secs(4);
    chk1("relief early", 1'b0, relay[0]);
    secs(2);
    chk1("relief on", 1'b1, relay[0]);
    ice <= 1'b0;
    cond <= 1'b1;
    secs(6);
    chk1("relief held", 1'b1, relay[0]);
    cond <= 1'b0;
    secs(4);
    chk1("relief late", 1'b1, relay[0]);
    secs(2);
    chk1("relief off", 1'b0, relay[0]);
    // Limit filter with a restart, then overlap
    lim <= 4'h1;
    secs(500);
    lim <= 4'h0;
    repeat (2) @(posedge clk);
    lim <= 4'h1;
    secs(1195);
    chk1("limit early", 1'b0, relay[1]);
    lim <= 4'h6;
    secs(10);
    chk1("limit on", 1'b1, relay[1]);
    lim <= 4'h0;
    secs(55);
    chk1("limit held", 1'b1, relay[1]);
    secs(7);
    chk1("limit off", 1'b0, relay[1]);
    // Default relays two and three: alarm and compressor running
    comp <= 2'h1;
    da <= 8'h01;
    repeat (3) @(posedge clk);
    chk("default relays", 32'hc, {28'h0, relay});
    // Alarm classes and warning on remapped relays, compressor running in the status word
    apb(1'b1, 8'h00, 32'h688);
    for (i = 0; i < 8; i = i + 1) begin
      da <= {7'h0, i[2]};
      dm <= {7'h0, i[1]};
      di <= {7'h0, i[0]};
      comp <= i[1:0];
      ev = {i[2] & i[0], i[2] & ~i[0],
            i[2] & ~i[0] & ~i[1], i[2] & ~i[0] & i[1]};
      repeat (3) @(posedge clk);
      chk("relays", {28'h0, ev}, {28'h0, relay});
      rchk("events", 8'h08, 32'h3f,
           {26'h0, |i[1:0], 1'b0, ev});
    end
    // Interrupt masked, unmasked, cleared by read
    da <= 8'h00;
    repeat (2) @(posedge clk);
    apb(1'b0, 8'h10, 32'h0);
    da <= 8'h01;
    dm <= 8'h00;
    di <= 8'h00;
    repeat (3) @(posedge clk);
    chk1("irq masked", 1'b0, irq);
    apb(1'b1, 8'h14, 32'h4);
    repeat (2) @(posedge clk);
    chk1("irq", 1'b1, irq);
    rchk("int stat", 8'h10, 32'h4, 32'h4);
    rchk("int clear", 8'h10, 32'h4, 32'h0);
    repeat (2) @(posedge clk);
    chk1("irq clear", 1'b0, irq);
    // Stop loop opens briefly
    eo <= 1'b1;
    repeat (10) @(posedge clk);
    eo <= 1'b0;
    repeat (10) @(posedge clk);
    chk1("trip", 1'b1, trip);
    rchk("latch ev", 8'h08, 32'h1, 32'h1);
    apb(1'b1, 8'h0c, 32'h1);
    repeat (3) @(posedge clk);
    chk1("trip clear", 1'b0, trip);
    // Auto/stop loop opens with compressors on
    comp <= 2'h1;
    ao <= 1'b1;
    repeat (10) @(posedge clk);
    chk1("unload", 1'b1, unl);
    chk1("inhibit", 1'b0, run);
    ao <= 1'b0;
    repeat (10) @(posedge clk);
    chk1("resume", 1'b1, run);
    chk1("unload end", 1'b0, unl);
    // Double press
    push;
    push;
    chk1("panic", 1'b1, panic);
    chk1("panic run", 1'b0, run);
    rchk("panic latch", 8'h08, 32'h1, 32'h0);
    apb(1'b1, 8'h0c, 32'h2);
    repeat (3) @(posedge clk);
    chk1("panic clear", 1'b0, panic);
    stop_test;
  end
endmodule
bind csrl_top csrl_checker #(.N_COMP(N_COMP)) u_chk (
  .REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
  .PWRITE_I(PWRITE_I), .PENABLE_I(PENABLE_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .COMP_RUN_I(COMP_RUN_I),
  .ESTOP_CLOSED_I(ESTOP_CLOSED_I), .AUTO_CLOSED_I(AUTO_CLOSED_I),
  .RUN_ENABLE_O(RUN_ENABLE_O), .UNLOAD_O(UNLOAD_O),
  .PANIC_STOP_O(PANIC_STOP_O), .ESTOP_TRIP_O(ESTOP_TRIP_O));
